// *** hw/dsa_pkg.sv ***
// constants and types shared by the dual-slope sequencer
package dsa_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W         = 4;
	localparam int unsigned DATA_W         = 32;
	localparam logic [3:0]  OFS_CTRL       = 4'h0;
	localparam logic [3:0]  OFS_HIGH_BYTE  = 4'h4;
	localparam logic [3:0]  OFS_STATUS     = 4'h8;
	localparam logic [3:0]  OFS_RESULT     = 4'hc;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_FORCE_AZ  = 0;
	localparam int unsigned STAT_PHASE_LO  = 0;
	localparam int unsigned STAT_SIGN      = 2;
	localparam int unsigned STAT_OVR       = 3;
	localparam int unsigned STAT_VALID     = 4;

	// ------------------------------------------------------------
	// sizes, counts and reset values
	// ------------------------------------------------------------
	localparam int unsigned SYS_DIV        = 4;
	localparam int unsigned HB_W           = 8;
	localparam int unsigned CNT_W          = 16;
	localparam int unsigned SHIFT_W        = 18;
	localparam int unsigned SYNC_W         = 6;
	localparam logic [7:0]  HB_RESET       = 8'h80;
	localparam logic [5:0]  SYNC_RESET     = 6'h30;

	// ------------------------------------------------------------
	// converter phases
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_ZERO_INT,
		PH_ZERO_OFFSET,
		PH_INTEGRATE,
		PH_DEINTEGRATE
	} dsa_phase_t;

endpackage

// *** hw/dsa_seq.sv ***
// dual-slope converter sequencer with serial load and read ports
//
// Notes on behaviour
// RULE1: phase length 256 to 65536 ticks, step 256
// RULE2: load low: shift byte msb first on rise
// RULE3: phase length is 256 times two's complement
// RULE4: 00 gives 65536, 80 32768, ff 256
// RULE5: load fall presets byte msb from data in
// RULE6: phase timer counts upward from preset
// RULE7: data out floats until read low
// RULE8: read fall loads 18-bit output shifter
// RULE9: over-range bit shows at once on read
// RULE10: falling clocks give sign, then count msb
// RULE11: excess clocks shift out zeros
// RULE12: conversions run, shifter frozen while reading
// RULE13: read may end early at any time
// RULE14: serial clock independent of system clock
// RULE15: system tick is core clock divided by 4
// RULE16: deintegrate lasts up to twice integrate
// RULE17: chip enable high forces zero offset phase
// RULE18: start in zero integrate, await comparator
// RULE19: host pulses load or chip enable at start
// RULE20: chip enable high drives a low, b high
// RULE21: load low forces zero offset phase
// RULE22: result valid goes low on new result
// RULE23: comparator gives sign and zero crossing
// RULE24: loop phases, over-range on counter overflow
// RULE25: results held, shifter loads only on read

// ------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ------------------------------------------------------------
module dsa_sync
	import dsa_pkg::*;
#(
	parameter int unsigned        WIDTH     = 1,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
)(
	input  wire logic             core_clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             clk_en_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] clean_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			stage1  <= RESET_VAL;
			stage2  <= RESET_VAL;
			stage3  <= RESET_VAL;
			clean_o <= RESET_VAL;
		end
		else if (clk_en_i)
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (stage2[i] == stage3[i])
					clean_o[i] <= stage3[i];
			end
		end
	end
endmodule // dsa_sync

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module dsa_seq
	import dsa_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	input  wire logic              comparator_i,
	input  wire logic              chip_enable_n_i,
	input  wire logic              load_n_i,
	input  wire logic              data_in_i,
	input  wire logic              data_clk_i,
	input  wire logic              read_n_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic                   phase_a_o,
	output logic                   phase_b_o,
	output logic                   result_valid_n_o,
	output logic                   data_out_o,
	output logic                   data_out_oe_n_o
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins;
	logic              comp_s;
	logic              ce_n_s;
	logic              load_n_s;
	logic              din_s;
	logic              dclk_s;
	logic              read_n_s;

	assign pins_raw = {read_n_i, load_n_i, data_clk_i, data_in_i, chip_enable_n_i, comparator_i};
	assign comp_s   = pins[0];
	assign ce_n_s   = pins[1];
	assign din_s    = pins[2];
	assign dclk_s   = pins[3];
	assign load_n_s = pins[4];
	assign read_n_s = pins[5];

	// serial clock is sampled, never used as a clock
	dsa_sync #(
		.WIDTH     (SYNC_W),
		.RESET_VAL (SYNC_RESET)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.clk_en_i   (clk_en_i),
		.async_i    (pins_raw),
		.clean_o    (pins)
	); // RULE14

	// ------------------------------------------------------------
	// edge detection on filtered pins
	// ------------------------------------------------------------
	logic dclk_d;
	logic load_n_d;
	logic read_n_d;
	logic dclk_rise;
	logic dclk_fall;
	logic load_fall;
	logic read_fall;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			dclk_d   <= 1'b0;
			load_n_d <= 1'b1;
			read_n_d <= 1'b1;
		end
		else if (clk_en_i)
		begin
			dclk_d   <= dclk_s;
			load_n_d <= load_n_s;
			read_n_d <= read_n_s;
		end
	end

	assign dclk_rise = dclk_s & ~dclk_d;
	assign dclk_fall = ~dclk_s & dclk_d;
	assign load_fall = ~load_n_s & load_n_d;
	assign read_fall = ~read_n_s & read_n_d;

	// ------------------------------------------------------------
	// system tick: core clock divided by four
	// ------------------------------------------------------------
	logic [1:0] div_cnt;
	logic       divided_system_clock;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			div_cnt <= 2'h0;
		else if (clk_en_i)
			div_cnt <= div_cnt + 2'h1;
	end

	assign divided_system_clock = (div_cnt == 2'(SYS_DIV - 1)); // RULE15

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	logic force_az;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			force_az <= 1'b0;
		else if (clk_en_i && reg_wr_i && reg_addr_i == OFS_CTRL)
			force_az <= reg_wdata_i[CTRL_FORCE_AZ];
	end

	// ------------------------------------------------------------
	// high byte of the phase timer
	// ------------------------------------------------------------
	logic [HB_W-1:0] high_byte;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			high_byte <= HB_RESET;
		else if (clk_en_i)
		begin
			if (load_fall)
				high_byte <= {din_s, 7'h00}; // RULE5
			else if (!load_n_s && dclk_rise)
				high_byte <= {high_byte[HB_W-2:0], din_s}; // RULE2
			else if (reg_wr_i && reg_addr_i == OFS_HIGH_BYTE)
				high_byte <= reg_wdata_i[HB_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// phase sequencer
	// ------------------------------------------------------------
	dsa_phase_t      phase;
	logic [CNT_W-1:0] timer;
	logic [17:0]     deint_cnt;
	logic [17:0]     deint_limit;
	logic [CNT_W-1:0] timer_preset;
	logic            force_zero_offset_phase;
	logic            timer_done;
	logic            sign_bit;
	logic            zero_cross;
	logic            deint_end;
	logic            deint_over;

	assign timer_preset            = {high_byte, 8'h00}; // RULE3
	assign timer_done              = (timer == 16'hffff); // RULE4
	assign force_zero_offset_phase = ce_n_s | ~load_n_s | force_az; // RULE17 RULE21
	// twice the integrate length: 2 * (65536 - preset)
	assign deint_limit = {(17'h10000 - {1'b0, timer_preset}), 1'b0}; // RULE16
	assign zero_cross  = (comp_s != sign_bit); // RULE23
	// result counter ran past 16 bits
	assign deint_over  = (deint_cnt[17:16] != 2'h0);
	assign deint_end   = zero_cross || (deint_cnt + 18'h1 >= deint_limit);

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			phase <= PH_ZERO_INT; // RULE18
			timer <= '0;
		end
		else if (clk_en_i)
		begin
			if (force_zero_offset_phase)
			begin
				phase <= PH_ZERO_OFFSET; // RULE20
				timer <= timer_preset;
			end
			else if (divided_system_clock)
			begin
				case (phase)
				PH_ZERO_INT:
				begin
					if (!comp_s)
					begin
						phase <= PH_ZERO_OFFSET; // RULE18
						timer <= timer_preset;
					end
				end
				PH_ZERO_OFFSET:
				begin
					if (timer_done)
					begin
						phase <= PH_INTEGRATE;
						timer <= timer_preset;
					end
					else
						timer <= timer + 16'h1; // RULE6 RULE1
				end
				PH_INTEGRATE:
				begin
					if (timer_done)
						phase <= PH_DEINTEGRATE;
					else
						timer <= timer + 16'h1; // RULE6
				end
				PH_DEINTEGRATE:
				begin
					if (deint_end)
						phase <= PH_ZERO_INT; // RULE24
				end
				default:
					phase <= PH_ZERO_INT;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// polarity, result counter and holding register
	// ------------------------------------------------------------
	logic [CNT_W-1:0] hold_count;
	logic             over_range_bit;
	logic             hold_sign;
	logic             result_done;

	assign result_done = divided_system_clock && !force_zero_offset_phase
		&& phase == PH_DEINTEGRATE && deint_end;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			sign_bit  <= 1'b0;
			deint_cnt <= '0;
		end
		else if (clk_en_i && divided_system_clock)
		begin
			if (phase == PH_INTEGRATE && timer_done)
			begin
				sign_bit  <= comp_s; // RULE23
				deint_cnt <= '0;
			end
			else if (phase == PH_DEINTEGRATE)
				deint_cnt <= deint_cnt + 18'h1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			hold_count     <= '0;
			over_range_bit <= 1'b0;
			hold_sign      <= 1'b0;
		end
		else if (clk_en_i && result_done)
		begin
			hold_count     <= deint_cnt[CNT_W-1:0]; // RULE25
			over_range_bit <= deint_over || !zero_cross; // RULE24
			hold_sign      <= sign_bit;
		end
	end

	// ------------------------------------------------------------
	// phase lines and result valid
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			phase_a_o <= 1'b0;
			phase_b_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (force_zero_offset_phase)
			begin
				phase_a_o <= 1'b0; // RULE20
				phase_b_o <= 1'b1;
			end
			else
			begin
				case (phase)
				PH_ZERO_INT:    {phase_a_o, phase_b_o} <= 2'h0;
				PH_ZERO_OFFSET: {phase_a_o, phase_b_o} <= 2'h1;
				PH_INTEGRATE:   {phase_a_o, phase_b_o} <= 2'h2;
				PH_DEINTEGRATE: {phase_a_o, phase_b_o} <= 2'h3;
				default:        {phase_a_o, phase_b_o} <= 2'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			result_valid_n_o <= 1'b1;
		else if (clk_en_i)
		begin
			if (result_done)
				result_valid_n_o <= 1'b0; // RULE22
			else if (read_fall || (phase == PH_INTEGRATE && divided_system_clock))
				result_valid_n_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// serial read shifter
	// ------------------------------------------------------------
	logic [SHIFT_W-1:0] out_shift;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			out_shift       <= '0;
			data_out_o      <= 1'b0;
			data_out_oe_n_o <= 1'b1;
		end
		else if (clk_en_i)
		begin
			data_out_oe_n_o <= read_n_s; // RULE7 RULE13
			if (read_fall)
			begin
				out_shift  <= {over_range_bit, hold_sign, hold_count}; // RULE8 RULE12
				data_out_o <= over_range_bit; // RULE9
			end
			else if (!read_n_s && dclk_fall)
			begin
				out_shift  <= {out_shift[SHIFT_W-2:0], 1'b0}; // RULE11
				data_out_o <= out_shift[SHIFT_W-2]; // RULE10
			end
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			reg_rdata_o <= '0;
		else if (clk_en_i)
		begin
			if (reg_rd_i)
			begin
				case (reg_addr_i)
				OFS_CTRL:      reg_rdata_o <= {31'h0, force_az};
				OFS_HIGH_BYTE: reg_rdata_o <= {24'h0, high_byte};
				OFS_STATUS:    reg_rdata_o <= {27'h0, ~result_valid_n_o, over_range_bit,
					hold_sign, phase};
				OFS_RESULT:    reg_rdata_o <= {14'h0, over_range_bit, hold_sign, hold_count};
				default:       reg_rdata_o <= '0;
				endcase
			end
			else
				reg_rdata_o <= '0;
		end
	end
endmodule // dsa_seq

// *** test/dsa_seq_properties.sv ***
// port assertions for the dual-slope sequencer
module dsa_seq_checker
	import dsa_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	input  wire logic              chip_enable_n_i,
	input  wire logic              load_n_i,
	input  wire logic              data_clk_i,
	input  wire logic              read_n_i,
	input  wire logic [DATA_W-1:0] reg_rdata_o,
	input  wire logic              phase_a_o,
	input  wire logic              phase_b_o,
	input  wire logic              result_valid_n_o,
	input  wire logic              data_out_o,
	input  wire logic              data_out_oe_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [1:0] ph;
	logic [3:0] quiet;
	assign ph = {phase_a_o, phase_b_o};

	// cycles with read low and data clock high
	always_ff @(posedge core_clk_i)
		if (!rst_b_i || read_n_i || !data_clk_i)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;

	ce_force_a:
	assert property ((clk_en_i && chip_enable_n_i)[*8] |-> ph == 2'h1)
		else $error("chip enable did not force zero offset");
	load_force_a:
	assert property ((clk_en_i && !load_n_i)[*8] |-> ph == 2'h1)
		else $error("load did not force zero offset");
	oe_idle_a:
	assert property ((clk_en_i && read_n_i)[*8] |-> data_out_oe_n_o)
		else $error("data out driven while not selected");
	oe_drive_a:
	assert property ((clk_en_i && !read_n_i)[*8] |-> !data_out_oe_n_o)
		else $error("data out not driven while selected");
	az_next_a:
	assert property (($past(rst_b_i) && $past(ph) == 2'h1 && ph != 2'h1) |-> ph == 2'h2)
		else $error("zero offset not followed by integrate");
	int_next_a:
	assert property (($past(rst_b_i) && $past(ph) == 2'h2 && ph != 2'h2)
		|-> ph inside {2'h3, 2'h1})
		else $error("integrate left to a wrong phase");
	valid_phase_a:
	assert property ($fell(result_valid_n_o) |-> ph == 2'h3)
		else $error("result valid fell outside result end");
	dout_hold_a:
	assert property (quiet >= 4'h4 |-> $stable(data_out_o))
		else $error("data out moved without clock edge");
endmodule // dsa_seq_checker

bind dsa_seq dsa_seq_checker i_dsa_seq_checker (.core_clk_i, .rst_b_i, .clk_en_i,
	.chip_enable_n_i, .load_n_i, .data_clk_i, .read_n_i, .reg_rdata_o, .phase_a_o,
	.phase_b_o, .result_valid_n_o, .data_out_o, .data_out_oe_n_o);

// *** test/dsa_integrator_model.sv ***
// behavioural integrator and comparator facing the sequencer
module dsa_integrator_model
(
	input  wire logic core_clk_i,
	input  wire logic phase_a_i,
	input  wire logic phase_b_i,
	input  wire logic sign_i,
	input  wire logic stuck_i,
	input  wire logic [31:0] deint_len_i,
	output logic      comparator_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int run;
	initial
	begin
		comparator_o = 1'b0;
		run = 0;
	end
	always @(posedge core_clk_i)
	begin
		run <= ({phase_a_i, phase_b_i} == 2'h3) ? run + 1 : 0;
		// polarity during integrate, zero crossing after deint_len_i
		case ({phase_a_i, phase_b_i})
			2'h2: comparator_o <= sign_i;
			2'h3: comparator_o <= (run >= deint_len_i && !stuck_i) ? !sign_i : sign_i;
			default: comparator_o <= 1'b0;
		endcase
	end
endmodule // dsa_integrator_model

// *** test/testbench.sv ***
// self-checking bench for the dual-slope sequencer
module testbench;
	import dsa_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i = 0, rst_b_i = 0, clk_en_i = 1, comparator_i, chip_enable_n_i = 0;
	logic load_n_i = 1, data_in_i = 0, data_clk_i = 0, read_n_i = 1, reg_wr_i = 0;
	logic reg_rd_i = 0, phase_a_o, phase_b_o, result_valid_n_o, data_out_o, data_out_oe_n_o;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, d;
	logic              stuck = 0;
	int                fail_count = 0, checks_done = 0, n;
	logic [15:0]       cnt;

	always #12.5 core_clk_i = ~core_clk_i;
	dsa_seq i_dsa_seq (.core_clk_i, .rst_b_i, .clk_en_i, .comparator_i, .chip_enable_n_i,
		.load_n_i, .data_in_i, .data_clk_i, .read_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .phase_a_o, .phase_b_o, .result_valid_n_o, .data_out_o,
		.data_out_oe_n_o);
	dsa_integrator_model i_dsa_integrator_model (.core_clk_i, .phase_a_i(phase_a_o),
		.phase_b_i(phase_b_o), .sign_i(1'b1), .stuck_i(stuck), .deint_len_i(400),
		.comparator_o(comparator_i));

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk_i);
	endtask
	task automatic reg_rd(input logic [3:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		cyc(1);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
		cyc(1);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		cyc(1);
		reg_wr_i <= 1'b0;
		cyc(1);
	endtask
	task automatic pulse(input logic b);
		data_in_i <= b;
		cyc(8);
		data_clk_i <= 1'b1;
		cyc(8);
		data_clk_i <= 1'b0;
		cyc(8);
	endtask
	// bounded waits for a phase code or a result valid level
	task automatic wait_ph(input logic [1:0] p);
		n = 0;
		while ({phase_a_o, phase_b_o} !== p && n < 20000)
		begin
			cyc(1);
			n++;
		end
		if (n >= 20000)
		begin
			check(n, 0);
			test_done();
		end
	endtask
	task automatic wait_rv(input logic v);
		n = 0;
		while (result_valid_n_o !== v && n < 20000)
		begin
			cyc(1);
			n++;
		end
		if (n >= 20000)
		begin
			check(n, 0);
			test_done();
		end
	endtask

	task automatic t_load();
		check(data_out_oe_n_o, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			data_in_i <= i[0];
			cyc(2);
			load_n_i <= 1'b0;
			cyc(10);
			check({phase_a_o, phase_b_o}, 2'h1);
			load_n_i <= 1'b1;
			cyc(10);
			reg_rd(OFS_HIGH_BYTE);
			check(d, {i[0], 7'h0});
		end
		load_n_i <= 1'b0;
		cyc(10);
		for (int i = 7; i >= 0; i--)
			pulse(i != 0);
		load_n_i <= 1'b1;
		cyc(10);
		reg_rd(OFS_HIGH_BYTE);
		check(d, 32'h000000fe);
		reg_rd(4'h2);
		check(d, 32'h0);
		$display("test load done");
	endtask
	task automatic t_timing();
		wait_ph(2'h2);
		wait_ph(2'h3);
		check(n >= 2044 && n <= 2052, 1'b1);
		wait_rv(1'b0);
		reg_rd(OFS_RESULT);
		check(d[17:16], 2'h1);
		check(d[15:0] >= 95 && d[15:0] <= 110, 1'b1);
		$display("test timing done");
	endtask
	task automatic t_serial();
		read_n_i <= 1'b0;
		cyc(10);
		check({data_out_oe_n_o, data_out_o}, 2'h0);
		pulse(1'b0);
		check(data_out_o, 1'b1);
		for (int i = 15; i >= 0; i--)
		begin
			pulse(1'b0);
			cnt[i] = data_out_o;
		end
		check(cnt >= 95 && cnt <= 110, 1'b1);
		wait_rv(1'b0);
		pulse(1'b0);
		check(data_out_o, 1'b0);
		read_n_i <= 1'b1;
		cyc(10);
		check(data_out_oe_n_o, 1'b1);
		$display("test serial done");
	endtask
	task automatic t_over();
		stuck <= 1'b1;
		wait_ph(2'h1);
		wait_rv(1'b1);
		wait_rv(1'b0);
		reg_rd(OFS_RESULT);
		check(d[17], 1'b1);
		stuck <= 1'b0;
		chip_enable_n_i <= 1'b1;
		cyc(200);
		check({phase_a_o, phase_b_o}, 2'h1);
		chip_enable_n_i <= 1'b0;
		$display("test overrange done");
	endtask
	task automatic t_regs();
		reg_wr(OFS_CTRL, 32'h00000001);
		cyc(4);
		check({phase_a_o, phase_b_o}, 2'h1);
		reg_rd(OFS_STATUS);
		check(d[1:0], 2'h1);
		reg_rd(OFS_CTRL);
		check(d, 32'h00000001);
		reg_wr(OFS_CTRL, 32'h00000000);
		reg_wr(OFS_HIGH_BYTE, 32'h000000ff);
		reg_rd(OFS_HIGH_BYTE);
		check(d, 32'h000000ff);
		$display("test registers done");
	endtask

	initial
	begin
		cyc(10);
		rst_b_i <= 1'b1;
		cyc(2);
		t_load();
		t_timing();
		t_serial();
		t_over();
		t_regs();
		test_done();
	end
endmodule // testbench
